// File: hw/dch_access_defs.svh
// Constants for the D channel and dump/restore overlay register logic.
//
// Contract
// - bank bit one overlays D channel port
// - overlay active ignores pin D channel data
// - receive bytes superframe aligned, loaded after the eighth bit
// - transmit byte moved out at superframe sync
// - new receive byte raises interrupt, code 1111
// - port read clears code, activation status kept
// - bytes pass transparently, no HDLC processing
// - serialise and assemble most significant bit first
// - bank bit two overlays dump/restore port
// - dump/restore mode from two config bits
// - dump/restore port register resets to zero
// - dump/restore mode encoding 00/10/01/11
// - bank select visible in both sets
`ifndef DCH_ACCESS_DEFS_SVH
`define DCH_ACCESS_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_NIBBLE_STATUS 4'h1
`define ADDR_OVERLAY_CONFIG_TWO 4'h8
`define ADDR_BANK_SELECT 4'ha
`define ADDR_BYTE_TWELVE 4'hc
`define ADDR_BYTE_THIRTEEN 4'hd

// ----------------------------------------------------------------------
// Field positions, reset values and codes
// ----------------------------------------------------------------------
`define BANK_OVERLAY_BIT 0
`define BANK_DCH_BIT 1
`define BANK_DUMP_BIT 2
`define CFG_DR_MODE_LSB 6
`define CFG_RESERVED_BIT 2
`define BYTE_RESET 8'h00
`define DCH_IDLE_BYTE 8'hff
`define DCH_SOURCE_CODE 4'hf
`define DCH_LAST_BIT 3'h7

`endif

// File: hw/dch_access_pkg.sv
// Types shared by the D channel and dump/restore overlay logic.
package dch_access_pkg;
  typedef enum logic [1:0]
  {
    dr_eye_dump_type = 2'b00,
    dr_arctap_write_type = 2'b10,
    dr_arctap_read_type = 2'b01,
    dr_tdm_dump_type = 2'b11
  } dr_mode_type;
endpackage : dch_access_pkg

// File: hw/d_channel_access_register.sv
// Overlay register bank with D channel byte port and dump/restore port.
`timescale 1ns/10ps
`default_nettype none
`include "dch_access_defs.svh"

module d_channel_access_register
  import dch_access_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic soft_reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [3:0] activation_status_in,
  input wire logic superframe_sync_in,
  input wire logic rx_dch_bit_in,
  input wire logic rx_dch_valid_in,
  input wire logic tx_dch_req_in,
  output logic tx_dch_bit_out,
  input wire logic pin_dch_bit_in,
  output logic [3:0] nibble_status_out,
  output logic third_interrupt_source_out,
  output logic [7:0] dump_wdata_out,
  output logic dump_wr_out,
  output logic dump_rd_out,
  input wire logic [7:0] dump_rdata_in,
  output var dr_mode_type dr_mode_out
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [7:0] bank_select_register, overlay_config_two, rx_hold, rx_shift;
  logic [7:0] normal_byte_reg_twelve, normal_byte_reg_thirteen, tx_hold;
  logic [7:0] dump_restore_byte_port, tx_shift;
  logic [2:0] rx_count, tx_count;
  logic tx_hold_full, dch_pending, pin_sync_a, pin_sync_b, clear_all;
  logic dch_overlay, dump_overlay, base_overlay, rx_byte_done, tx_reload;
  logic wr_dch, rd_dch, wr_dump, rd_dump;

  // Software reset clears the same state as hardware reset, except the pin synchronisers and the read data and read valid registers.
  assign clear_all = soft_reset_in;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Decides whether an access hits the given address.
  function automatic logic hit(input logic [3:0] addr, target);
    hit = (addr == target);
  endfunction : hit

  // Overlay selection follows the bank bits as they stand now.
  assign base_overlay = bank_select_register[`BANK_OVERLAY_BIT];
  assign dch_overlay = bank_select_register[`BANK_DCH_BIT];
  assign dump_overlay = bank_select_register[`BANK_DUMP_BIT];
  assign wr_dch = ce_in && reg_wr_in && dch_overlay &&
                  hit(reg_addr_in, `ADDR_BYTE_TWELVE);
  assign rd_dch = ce_in && reg_rd_in && dch_overlay &&
                  hit(reg_addr_in, `ADDR_BYTE_TWELVE);
  assign wr_dump = ce_in && reg_wr_in && dump_overlay &&
                   hit(reg_addr_in, `ADDR_BYTE_THIRTEEN);
  assign rd_dump = ce_in && reg_rd_in && dump_overlay &&
                   hit(reg_addr_in, `ADDR_BYTE_THIRTEEN);

  // --------------------------------------------------------------------
  // Bank select and configuration
  // --------------------------------------------------------------------
  // The bank register answers whatever set is selected, so software
  // can always find its way back to the basic set.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      bank_select_register <= `BYTE_RESET;
    else if (ce_in)
    begin
      if (clear_all)
        bank_select_register <= `BYTE_RESET;
      else if (reg_wr_in && hit(reg_addr_in, `ADDR_BANK_SELECT))
        bank_select_register <= reg_wdata_in;
    end
  end

  // Configuration two lives in the overlay set; the reserved bit is
  // forced low because it must never be set.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      overlay_config_two <= `BYTE_RESET;
    else if (ce_in)
    begin
      if (clear_all)
        overlay_config_two <= `BYTE_RESET;
      else if (reg_wr_in && base_overlay &&
               hit(reg_addr_in, `ADDR_OVERLAY_CONFIG_TWO))
      begin
        overlay_config_two <= reg_wdata_in;
        overlay_config_two[`CFG_RESERVED_BIT] <= 1'b0;
      end
    end
  end

  // Mode bits travel straight to the dump/restore engine.
  assign dr_mode_out = dr_mode_type'(
    overlay_config_two[`CFG_DR_MODE_LSB +: 2]);

  // Normal byte registers stay intact under the overlays.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      normal_byte_reg_twelve <= `BYTE_RESET;
      normal_byte_reg_thirteen <= `BYTE_RESET;
    end
    else if (ce_in)
    begin
      if (clear_all)
      begin
        normal_byte_reg_twelve <= `BYTE_RESET;
        normal_byte_reg_thirteen <= `BYTE_RESET;
      end
      else if (reg_wr_in && !dch_overlay &&
               hit(reg_addr_in, `ADDR_BYTE_TWELVE))
        normal_byte_reg_twelve <= reg_wdata_in;
      else if (reg_wr_in && !dump_overlay &&
               hit(reg_addr_in, `ADDR_BYTE_THIRTEEN))
        normal_byte_reg_thirteen <= reg_wdata_in;
    end
  end

  // --------------------------------------------------------------------
  // Dump/restore port
  // --------------------------------------------------------------------
  // Written bytes are held for the dump engine and strobed once.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      dump_restore_byte_port <= `BYTE_RESET;
    else if (ce_in)
    begin
      if (clear_all)
        dump_restore_byte_port <= `BYTE_RESET;
      else if (wr_dump)
        dump_restore_byte_port <= reg_wdata_in;
    end
  end

  assign dump_wdata_out = dump_restore_byte_port;
  assign dump_wr_out = wr_dump && !clear_all;
  assign dump_rd_out = rd_dump && !clear_all;

  // --------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------
  // Bits are shifted in at the right side; the sync pulse restarts the
  // byte count so every byte begins on the superframe boundary.
  assign rx_byte_done = rx_dch_valid_in && !superframe_sync_in &&
                        (rx_count == `DCH_LAST_BIT);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_shift <= `BYTE_RESET;
      rx_count <= 3'h0;
    end
    else if (ce_in)
    begin
      if (clear_all || superframe_sync_in)
        rx_count <= 3'h0;
      else if (rx_dch_valid_in)
        rx_count <= rx_count + 3'h1;
      if (clear_all)
        rx_shift <= `BYTE_RESET;
      else if (rx_dch_valid_in)
        rx_shift <= {rx_shift[6:0], rx_dch_bit_in};
    end
  end

  // The receive buffer takes each finished byte unchanged.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rx_hold <= `BYTE_RESET;
    else if (ce_in)
    begin
      if (clear_all)
        rx_hold <= `BYTE_RESET;
      else if (rx_byte_done)
        rx_hold <= {rx_shift[6:0], rx_dch_bit_in};
    end
  end

  // The pending flag marks a byte waiting to be read; a new byte in the
  // same cycle as the read keeps it set so no byte goes unnoticed.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      dch_pending <= 1'b0;
    else if (ce_in)
    begin
      if (clear_all)
        dch_pending <= 1'b0;
      else if (rx_byte_done && dch_overlay)
        dch_pending <= 1'b1;
      else if (rd_dch)
        dch_pending <= 1'b0;
    end
  end

  // The source code masks the activation nibble only while pending, so
  // an activation change stays visible once the byte has been read.
  assign nibble_status_out = dch_pending ? `DCH_SOURCE_CODE :
                             activation_status_in;
  assign third_interrupt_source_out = dch_pending;

  // --------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------
  // Pin data is resynchronised before the line mux may look at it.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_sync_a <= 1'b0;
      pin_sync_b <= 1'b0;
    end
    else if (ce_in)
    begin
      pin_sync_a <= pin_dch_bit_in;
      pin_sync_b <= pin_sync_a;
    end
  end

  // A byte boundary is reached at sync or after the eighth bit.
  assign tx_reload = superframe_sync_in ||
                     (tx_dch_req_in && tx_count == `DCH_LAST_BIT);

  // Holding buffer; a write landing on a reload is kept for the next
  // boundary rather than being lost.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_hold <= `DCH_IDLE_BYTE;
      tx_hold_full <= 1'b0;
    end
    else if (ce_in)
    begin
      if (clear_all)
      begin
        tx_hold <= `DCH_IDLE_BYTE;
        tx_hold_full <= 1'b0;
      end
      else if (wr_dch)
      begin
        tx_hold <= reg_wdata_in;
        tx_hold_full <= 1'b1;
      end
      else if (tx_reload)
        tx_hold_full <= 1'b0;
    end
  end

  // Shift register sends the top bit first; idle ones fill the gap when
  // software has not supplied a byte in time.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_shift <= `DCH_IDLE_BYTE;
      tx_count <= 3'h0;
    end
    else if (ce_in)
    begin
      if (clear_all)
      begin
        tx_shift <= `DCH_IDLE_BYTE;
        tx_count <= 3'h0;
      end
      else if (tx_reload)
      begin
        tx_shift <= tx_hold_full ? tx_hold : `DCH_IDLE_BYTE;
        tx_count <= 3'h0;
      end
      else if (tx_dch_req_in)
      begin
        tx_shift <= {tx_shift[6:0], 1'b1};
        tx_count <= tx_count + 3'h1;
      end
    end
  end

  // The overlay shuts the pin source out completely.
  assign tx_dch_bit_out = dch_overlay ? tx_shift[7] :
                          pin_sync_b;

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Read data is registered and shows one cycle after the strobe.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= `BYTE_RESET;
      reg_rvalid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
      begin
        unique case (reg_addr_in)
          `ADDR_NIBBLE_STATUS:
            reg_rdata_out <= {4'h0, nibble_status_out};
          `ADDR_OVERLAY_CONFIG_TWO:
            reg_rdata_out <= base_overlay ? overlay_config_two : `BYTE_RESET;
          `ADDR_BANK_SELECT:
            reg_rdata_out <= bank_select_register;
          `ADDR_BYTE_TWELVE:
            reg_rdata_out <= dch_overlay ? rx_hold :
                             normal_byte_reg_twelve;
          `ADDR_BYTE_THIRTEEN:
            reg_rdata_out <= dump_overlay ? dump_rdata_in :
                             normal_byte_reg_thirteen;
          default:
            reg_rdata_out <= `BYTE_RESET;
        endcase
      end
    end
  end

endmodule : d_channel_access_register
`default_nettype wire

// File: tb/dch_line_model.sv
// Line side model: superframe sync, receive bits and transmit requests.
`timescale 1ns/10ps
`default_nettype none
module line_model
(
  input wire logic clk_in,
  input wire logic tx_dch_bit_in,
  output logic superframe_sync_out,
  output logic rx_dch_bit_out,
  output logic rx_dch_valid_out,
  output logic tx_dch_req_out
);
  // Line outputs start idle.
  initial
  begin
    superframe_sync_out = 1'b0;
    rx_dch_bit_out = 1'b0;
    rx_dch_valid_out = 1'b0;
    tx_dch_req_out = 1'b0;
  end

  // One superframe: a sync pulse, then eight bit slots in both directions.
  // Each frame opens with a sync so the transmit byte stays aligned.
  task automatic frame(input logic [7:0] rx_byte,
                       output logic [7:0] tx_byte);
    int i;
    @(negedge clk_in);
    superframe_sync_out = 1'b1;
    @(negedge clk_in);
    superframe_sync_out = 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      tx_byte[i] = tx_dch_bit_in;
      rx_dch_bit_out = rx_byte[i];
      rx_dch_valid_out = 1'b1;
      tx_dch_req_out = 1'b1;
      @(negedge clk_in);
    end
    rx_dch_valid_out = 1'b0;
    tx_dch_req_out = 1'b0;
    rx_dch_bit_out = ~rx_byte[0]; // Idle line must not look like data.
  endtask : frame
endmodule : line_model
`default_nettype wire

// File: tb/dch_access_sva.sv
// Port checker for the overlay register bank.
`timescale 1ns/10ps
`default_nettype none
module dch_access_sva
  import dch_access_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic soft_reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rvalid_out,
  input wire logic [3:0] activation_status_in,
  input wire logic rx_dch_valid_in,
  input wire logic [3:0] nibble_status_out,
  input wire logic third_interrupt_source_out,
  input wire logic [7:0] dump_wdata_out,
  input wire logic dump_wr_out,
  input wire logic dump_rd_out,
  input wire dr_mode_type dr_mode_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // Named steps
  // ----------------------------------------------------------------
  sequence rd_taken;
    ce_in && reg_rd_in;
  endsequence
  sequence soft_clear;
    ce_in && soft_reset_in;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RVALID: assert property (rd_taken |=> reg_rvalid_out)
    else $error("read gave no read valid");
  AST_RVALID_SRC: assert property (
    reg_rvalid_out |-> $past(ce_in && reg_rd_in))
    else $error("read valid without a read");
  AST_DUMP_WR: assert property (
    dump_wr_out |-> reg_wr_in && reg_addr_in == 4'hd)
    else $error("dump write pulse without port write");
  AST_DUMP_DATA: assert property (
    dump_wr_out && !soft_reset_in |=> dump_wdata_out == $past(reg_wdata_in))
    else $error("dump data not the written byte");
  AST_DUMP_RD: assert property (
    dump_rd_out |-> reg_rd_in && reg_addr_in == 4'hd)
    else $error("dump read pulse without port read");
  AST_IRQ_CODE: assert property (
    third_interrupt_source_out |-> nibble_status_out == 4'hf)
    else $error("pending byte without source code");
  AST_NIBBLE_PASS: assert property (
    !third_interrupt_source_out |-> nibble_status_out == activation_status_in)
    else $error("activation status lost");
  AST_IRQ_CAUSE: assert property (
    $rose(third_interrupt_source_out) |-> $past(rx_dch_valid_in))
    else $error("interrupt without a received bit");
  AST_MODE_SRC: assert property (
    !$stable(dr_mode_out) |->
      $past(reg_wr_in && reg_addr_in == 4'h8) || $past(soft_reset_in))
    else $error("mode moved without a config write");
  AST_SOFT_RST: assert property (
    soft_clear |=> dump_wdata_out == 8'h00 && dr_mode_out == dr_eye_dump_type)
    else $error("soft reset left dump state");
endmodule : dch_access_sva

bind d_channel_access_register dch_access_sva chk (.clk_in(clk_in),
  .rst_in(rst_in), .ce_in(ce_in), .soft_reset_in(soft_reset_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rvalid_out(reg_rvalid_out),
  .activation_status_in(activation_status_in),
  .rx_dch_valid_in(rx_dch_valid_in), .nibble_status_out(nibble_status_out),
  .third_interrupt_source_out(third_interrupt_source_out),
  .dump_wdata_out(dump_wdata_out), .dump_wr_out(dump_wr_out),
  .dump_rd_out(dump_rd_out), .dr_mode_out(dr_mode_out));
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the overlay register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dch_access_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic soft_reset_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out, tx_dch_bit_out, third_interrupt_source_out;
  logic [3:0] activation_status_in = 4'h5;
  logic superframe_sync_in, rx_dch_bit_in, rx_dch_valid_in, tx_dch_req_in;
  logic pin_dch_bit_in = 1'b0;
  logic [3:0] nibble_status_out;
  logic [7:0] dump_wdata_out, txb, rxb, txe;
  logic dump_wr_out, dump_rd_out;
  logic [7:0] dump_rdata_in = 8'h00;
  dr_mode_type dr_mode_out;
  logic [31:0] seed = 32'ha5571288;
  logic [7:0] expect_q[$];
  int fail_count = 0;
  int compares = 0;
  int m;

  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end

  d_channel_access_register dut (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .soft_reset_in(soft_reset_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .activation_status_in(activation_status_in),
    .superframe_sync_in(superframe_sync_in), .rx_dch_bit_in(rx_dch_bit_in),
    .rx_dch_valid_in(rx_dch_valid_in), .tx_dch_req_in(tx_dch_req_in),
    .tx_dch_bit_out(tx_dch_bit_out), .pin_dch_bit_in(pin_dch_bit_in),
    .nibble_status_out(nibble_status_out),
    .third_interrupt_source_out(third_interrupt_source_out),
    .dump_wdata_out(dump_wdata_out), .dump_wr_out(dump_wr_out),
    .dump_rd_out(dump_rd_out), .dump_rdata_in(dump_rdata_in),
    .dr_mode_out(dr_mode_out));
  line_model line (.clk_in(clk_in), .tx_dch_bit_in(tx_dch_bit_out),
    .superframe_sync_out(superframe_sync_in), .rx_dch_bit_out(rx_dch_bit_in),
    .rx_dch_valid_out(rx_dch_valid_in), .tx_dch_req_out(tx_dch_req_in));

  // Pin data toggles while seed bit 5 is clear; the overlay must not let it through.
  always @(negedge clk_in)
    pin_dch_bit_in <= ~pin_dch_bit_in ^ seed[5];

  // One step of the 32-bit linear feedback shift register.
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  // Eight LFSR steps per draw so consecutive bytes are not shifted copies.
  task automatic next_rand();
    repeat (8) seed = lfsr_step(seed);
  endtask : next_rand

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] want);
    compares++;
    if (seen !== want)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  // The expected byte is noted now and matched when read valid shows.
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    expect_q.push_back(want);
    @(negedge clk_in);
    reg_rd_in = 1'b0;
  endtask : rd

  always @(negedge clk_in)
    if (reg_rvalid_out === 1'b1)
      check("read data", reg_rdata_out, expect_q.pop_front());

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Watchdog against a stuck run.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    check("dump data", dump_wdata_out, 8'h00);
    check("mode", {6'h00, dr_mode_out}, 8'h00);
    wr(4'ha, 8'h07);
    rd(4'ha, 8'h07);
    rd(4'h3, 8'h00);
    $display("test registers done");
    // Every mode code; the reserved bit is written 1 and must read 0.
    for (m = 0; m < 4; m++)
    begin
      wr(4'h8, {m[1:0], 6'h04});
      check("mode", {6'h00, dr_mode_out}, {6'h00, m[1:0]});
      rd(4'h8, {m[1:0], 6'h00});
    end
    next_rand();
    wr(4'hd, seed[7:0]);
    check("dump data", dump_wdata_out, seed[7:0]);
    dump_rdata_in = seed[15:8];
    rd(4'hd, seed[15:8]);
    $display("test modes and dump done");
    // A flag pattern first shows that nothing is framed or stuffed.
    for (m = 0; m < 3; m++)
    begin
      next_rand();
      txe = (m == 0) ? 8'h7e : seed[7:0];
      rxb = (m == 0) ? 8'h7e : seed[15:8];
      wr(4'hc, txe);
      line.frame(rxb, txb);
      check("tx byte", txb, txe);
      check("irq", {7'h00, third_interrupt_source_out}, 8'h01);
      rd(4'h1, 8'h0f);
      activation_status_in = seed[19:16];
      rd(4'hc, rxb);
      check("irq", {7'h00, third_interrupt_source_out}, 8'h00);
      check("nibble", {4'h0, nibble_status_out}, {4'h0, seed[19:16]});
    end
    $display("test d channel done");
    @(negedge clk_in);
    soft_reset_in = 1'b1;
    @(negedge clk_in);
    soft_reset_in = 1'b0;
    check("dump data", dump_wdata_out, 8'h00);
    check("mode", {6'h00, dr_mode_out}, 8'h00);
    rd(4'ha, 8'h00);
    // Basic set: plain bytes come back, ports and interrupt stay quiet.
    next_rand();
    wr(4'hc, seed[23:16]);
    wr(4'hd, seed[31:24]);
    check("dump data", dump_wdata_out, 8'h00);
    line.frame(8'h5a, txb);
    check("irq", {7'h00, third_interrupt_source_out}, 8'h00);
    rd(4'hc, seed[23:16]);
    rd(4'hd, seed[31:24]);
    // A low clock enable must keep a write from landing.
    @(negedge clk_in);
    ce_in = 1'b0;
    wr(4'ha, 8'h07);
    ce_in = 1'b1;
    rd(4'ha, 8'h00);
    repeat (2) @(negedge clk_in);
    check("reads left", 8'(expect_q.size()), 8'h00);
    $display("test soft reset done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
